// >>> hdl/srw_supervisor.sv
`timescale 1ns/100ps
module srw_supervisor
  import srw_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES,
  parameter int unsigned HOLD_TICKS = RESET_HOLD_TICKS,
  parameter int unsigned WD_TICKS = WDOG_TICKS
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic supply_rail_low_in,
  input wire logic manual_reset_n_in,
  input wire logic watchdog_kick_in,
  input wire logic watchdog_kick_float_in,
  input wire logic power_fail_sense_in,
  output logic reset_n_out,
  output logic reset_out,
  output logic watchdog_timeout_n_out,
  output logic power_fail_warn_n_out
);
  typedef enum logic [1:0] {ST_HELD, ST_PULSE, ST_RUN} srw_state_t;

  srw_sync_if syn();
  srw_state_t state_q;
  logic [CNT_W-1:0] divCnt_q;
  logic tick;
  logic [CNT_W-1:0] holdCnt_q;
  logic [CNT_W-1:0] wdCnt_q;
  logic kickPrev_q;
  logic kickEdge;
  logic expired_q;
  logic rstN_q;
  logic cause;

  srw_input_sync u_sync (
    .clk(clk),
    .rst(rst),
    .supplyLowIn(supply_rail_low_in),
    .manualRstNIn(manual_reset_n_in),
    .kickIn(watchdog_kick_in),
    .kickFloatIn(watchdog_kick_float_in),
    .pfBelowIn(power_fail_sense_in),
    .out(syn)
  );

  // One shared timebase for every interval
  always_ff @(posedge clk) begin
    if (rst || divCnt_q == CNT_W'(TICK_CYC - 1)) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= divCnt_q + CNT_W'(1);
    end
  end
  assign tick = (divCnt_q == CNT_W'(TICK_CYC - 1));

  // Either low supply or manual reset holds reset asserted
  assign cause = syn.supplyLow || !syn.manualRstN;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_HELD;
    end else begin
      case (state_q)
        ST_HELD: if (!cause) state_q <= ST_PULSE;
        ST_PULSE: begin
          if (cause) begin
            state_q <= ST_HELD;
          end else if (tick && holdCnt_q >= CNT_W'(HOLD_TICKS)) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: if (cause) state_q <= ST_HELD;
        default: state_q <= ST_HELD;
      endcase
    end
  end

  // Hold restarts when the cause ends, so the full 200 ms always follows
  // the last brownout or bounce; sub-tick phase adds at most one tick.
  always_ff @(posedge clk) begin
    if (rst || state_q != ST_PULSE || cause) begin
      holdCnt_q <= '0;
    end else if (tick) begin
      holdCnt_q <= holdCnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rstN_q <= 1'b0;
    end else begin
      rstN_q <= (state_q == ST_RUN) && !cause;
    end
  end
  assign reset_n_out = rstN_q;
  assign reset_out = ~rstN_q;

  // Synchronised kick sampled every cycle; 50 ns spans ten clocks
  always_ff @(posedge clk) begin
    if (rst) begin
      kickPrev_q <= 1'b0;
    end else begin
      kickPrev_q <= syn.kick;
    end
  end
  assign kickEdge = (kickPrev_q != syn.kick) && !syn.kickFloat;

  always_ff @(posedge clk) begin
    if (rst || !rstN_q || syn.kickFloat || kickEdge) begin
      wdCnt_q <= '0;
      expired_q <= 1'b0;
    end else if (tick && !expired_q) begin
      // Counting resumes once reset released with a driven kick
      if (wdCnt_q >= CNT_W'(WD_TICKS - 1)) begin
        expired_q <= 1'b1;
      end else begin
        wdCnt_q <= wdCnt_q + CNT_W'(1);
      end
    end
  end

  // Low supply forces timeout low; no minimum width, freed on recovery
  always_ff @(posedge clk) begin
    if (rst) begin
      watchdog_timeout_n_out <= 1'b0;
    end else begin
      watchdog_timeout_n_out <= !(syn.supplyLow || expired_q);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      power_fail_warn_n_out <= 1'b0;
    end else begin
      power_fail_warn_n_out <= !syn.pfBelow;
    end
  end
  // Timeout is not tied to reset here; the board loops it back
endmodule : srw_supervisor

// >>> hdl/srw_pkg.sv
// Notes on behaviour
// - Reset output stays asserted while supply is below threshold.
// - After supply rises above threshold, reset is held a nominal 200 ms.
// - Supply dropping below threshold asserts reset and starts a pulse.
// - Brownout during a reset pulse extends it by at least 140 ms more.
// - Active-high reset is always the exact complement of active-low reset.
// - Driven kick input with no toggle for 1.6 s drives timeout low.
// - Watchdog counter cleared and stopped during reset or floating kick.
// - Watchdog counts once reset releases and kick input is driven.
// - A kick pulse as short as 50 ns restarts the watchdog count.
// - Timeout output is low while supply is below threshold.
// - Floating kick disables watchdog; timeout then only shows low supply.
// - Power-fail warning low while sense input is below the reference.
// - Manual reset triggers a pulse of at least 140 ms, absorbing bounce.
// - Manual reset release is followed by a further nominal 200 ms hold.
// - Timeout output stays low after expiry until the counter is cleared.
// - Timeout output releases at once when supply recovers.
// - Every rising or falling kick edge clears the watchdog counter.
package srw_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned RESET_HOLD_MS = 200;
  localparam int unsigned RESET_HOLD_TICKS = RESET_HOLD_MS * 1000 / TICK_US;
  localparam int unsigned WDOG_TIMEOUT_MS = 1600;
  localparam int unsigned WDOG_TICKS = WDOG_TIMEOUT_MS * 1000 / TICK_US;
  localparam int unsigned KICK_PULSE_NS = 50;
  localparam int unsigned SYNC_STAGES = 2;
  // Sync reset bits {pf, kick, manualN, kickFloat, supplyLow}
  localparam logic [4:0] SYNC_RESET_BITS = 5'h07;
  localparam int unsigned CNT_W = 32;
endpackage : srw_pkg

// >>> hdl/srw_sync_if.sv
`timescale 1ns/100ps
interface srw_sync_if;
  logic supplyLow;
  logic manualRstN;
  logic kick;
  logic kickFloat;
  logic pfBelow;
  modport src (output supplyLow, manualRstN, kick, kickFloat, pfBelow);
  modport dst (input supplyLow, manualRstN, kick, kickFloat, pfBelow);
endinterface : srw_sync_if

// >>> hdl/srw_input_sync.sv
`timescale 1ns/100ps
module srw_input_sync
  import srw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic supplyLowIn,
  input wire logic manualRstNIn,
  input wire logic kickIn,
  input wire logic kickFloatIn,
  input wire logic pfBelowIn,
  srw_sync_if.src out
);
  logic [4:0] stage1Q;
  logic [4:0] stage2Q;
  // Safe reset values: supply low, no manual reset, kick floating
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1Q <= SYNC_RESET_BITS;
      stage2Q <= SYNC_RESET_BITS;
    end else begin
      stage1Q <= {pfBelowIn, kickIn, manualRstNIn, kickFloatIn, supplyLowIn};
      stage2Q <= stage1Q;
    end
  end
  assign out.supplyLow = stage2Q[0];
  assign out.kickFloat = stage2Q[1];
  assign out.manualRstN = stage2Q[2];
  assign out.kick = stage2Q[3];
  assign out.pfBelow = stage2Q[4];
endmodule : srw_input_sync

// >>> sim/srw_chk.sv
`timescale 1ns/100ps
module srw_chk #(
  parameter int unsigned TICK_CYC = 4,
  parameter int unsigned HOLD_TICKS = 5,
  parameter int unsigned WD_TICKS = 8
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic supply_rail_low_in,
  input wire logic manual_reset_n_in,
  input wire logic watchdog_kick_in,
  input wire logic watchdog_kick_float_in,
  input wire logic power_fail_sense_in,
  input wire logic reset_n_out,
  input wire logic reset_out,
  input wire logic watchdog_timeout_n_out,
  input wire logic power_fail_warn_n_out
);
  localparam int HOLD = TICK_CYC * HOLD_TICKS;
  localparam int WD = TICK_CYC * WD_TICKS;
  int calm_q;
  int supOk_q;
  int idle_q;
  logic kickLast_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Raw-input counters; the sync delay only makes the design later
  always_ff @(posedge clk) calm_q <= (rst || supply_rail_low_in || !manual_reset_n_in) ?
    0 : calm_q + 1;
  always_ff @(posedge clk) supOk_q <= (rst || supply_rail_low_in) ? 0 : supOk_q + 1;
  always_ff @(posedge clk) kickLast_q <= watchdog_kick_in;
  always_ff @(posedge clk) idle_q <= (rst || !reset_n_out || watchdog_kick_float_in ||
    watchdog_kick_in != kickLast_q) ? 0 : idle_q + 1;
  a_rst_complement: assert property (reset_out == !reset_n_out)
    else $error("reset pair");
  a_supply_holds_rst: assert property (supply_rail_low_in [*4] |-> !reset_n_out)
    else $error("low supply");
  a_manual_holds_rst: assert property (!manual_reset_n_in [*4] |-> !reset_n_out)
    else $error("manual");
  a_pf_warn_low: assert property (power_fail_sense_in [*4] |-> !power_fail_warn_n_out)
    else $error("pf low");
  a_hold_min_len: assert property ($rose(reset_n_out) |-> calm_q >= HOLD)
    else $error("hold short");
  a_hold_max_len: assert property (calm_q > HOLD + TICK_CYC + 12 |-> reset_n_out)
    else $error("hold long");
  a_wdo_not_early: assert property ($fell(watchdog_timeout_n_out) |->
    idle_q >= WD - TICK_CYC || supOk_q < 6) else $error("wdo early");
  a_wdo_expiry_holds: assert property (idle_q > WD + TICK_CYC + 8 |-> !watchdog_timeout_n_out)
    else $error("wdo late");
endmodule : srw_chk

// >>> sim/srw_cpu_model.sv
`timescale 1ns/100ps
module srw_cpu_model (
  input wire logic clk,
  input wire logic [7:0] gap,
  input wire logic hiZ,
  input wire logic wdoN,
  input wire logic link,
  input wire logic btnN,
  output logic kick,
  output logic kickFloat,
  output logic mrN
);
  logic [7:0] cnt_q = 8'h00;
  logic kick_q = 1'b0;
  assign kick = kick_q;
  assign kickFloat = hiZ;
  assign mrN = btnN & (wdoN | !link);
  always_ff @(posedge clk) begin
    cnt_q <= (cnt_q >= gap) ? 8'h00 : cnt_q + 8'h01;
    // Released pin wanders, never holds its last level
    if (hiZ || (gap != 8'h00 && cnt_q >= gap)) kick_q <= !kick_q;
  end
endmodule : srw_cpu_model

// >>> sim/supervisor_reset_watchdog_tb_top.sv
`timescale 1ns/100ps
module supervisor_reset_watchdog_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic supLow = 1'b0;
  logic pfSense = 1'b0;
  logic btnN = 1'b1;
  logic hiZ = 1'b0;
  logic link = 1'b0;
  logic [7:0] gap = 8'h09;
  logic kick, kickFloat, mrN, rstN, rstOut, wdoN, warnN;
  logic [31:0] seed = 32'h51;
  int mismatches = 0;
  int num_checks = 0;
  int n;
  srw_cpu_model cpu (.clk(clk), .gap(gap), .hiZ(hiZ), .wdoN(wdoN), .link(link), .btnN(btnN),
    .kick(kick), .kickFloat(kickFloat), .mrN(mrN));
  srw_supervisor #(.TICK_CYC(4), .HOLD_TICKS(5), .WD_TICKS(8)) dut (.clk(clk), .rst(rst),
    .supply_rail_low_in(supLow), .manual_reset_n_in(mrN), .watchdog_kick_in(kick),
    .watchdog_kick_float_in(kickFloat), .power_fail_sense_in(pfSense), .reset_n_out(rstN),
    .reset_out(rstOut), .watchdog_timeout_n_out(wdoN), .power_fail_warn_n_out(warnN));
  initial forever #2.5 clk = !clk;
  function logic rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[3];
  endfunction : rnd
  function logic warnExp(input logic sense);
    return !sense;
  endfunction : warnExp
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wrap_up();
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task waitOn(input bit onWdo, input logic v);
    for (n = 0; (onWdo ? wdoN : rstN) !== v; n++) begin
      if (n == 300) begin
        mismatches++;
        wrap_up();
      end
      @(posedge clk) #1;
    end
  endtask : waitOn
  task step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : step
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    waitOn(0, 1'h1);
    chk(n >= 20, 1'h1);
    repeat (8) begin
      @(posedge clk) pfSense <= rnd();
      step(5);
      chk(warnN, warnExp(pfSense));
    end
    step(60);
    chk(wdoN, 1'h1);
    @(posedge clk) gap <= 8'h00;
    waitOn(1, 1'h0);
    chk(n >= 18 && n <= 44, 1'h1);
    step(20);
    chk(wdoN, 1'h0);
    @(posedge clk) gap <= 8'h09;
    waitOn(1, 1'h1);
    chk(n <= 16, 1'h1);
    @(posedge clk) hiZ <= 1'b1;
    gap <= 8'h00;
    step(100);
    chk(wdoN, 1'h1);
    @(posedge clk) hiZ <= 1'b0;
    waitOn(1, 1'h0);
    chk(n <= 44, 1'h1);
    @(posedge clk) supLow <= 1'b1;
    step(5);
    chk({rstN, wdoN}, 2'h0);
    @(posedge clk) supLow <= 1'b0;
    waitOn(1, 1'h1);
    chk(n <= 5, 1'h1);
    step(8);
    @(posedge clk) supLow <= 1'b1;
    step(3);
    @(posedge clk) supLow <= 1'b0;
    waitOn(0, 1'h1);
    chk(n >= 20, 1'h1);
    repeat (12) @(posedge clk) btnN <= rnd();
    @(posedge clk) btnN <= 1'b0;
    step(4);
    chk({rstN, rstOut}, 2'h1);
    @(posedge clk) btnN <= 1'b1;
    waitOn(0, 1'h1);
    chk(n >= 20, 1'h1);
    @(posedge clk) link <= 1'b1;
    waitOn(0, 1'h0);
    chk(n <= 50, 1'h1);
    wrap_up();
  end
endmodule : supervisor_reset_watchdog_tb_top
bind srw_supervisor srw_chk #(.TICK_CYC(TICK_CYC), .HOLD_TICKS(HOLD_TICKS), .WD_TICKS(WD_TICKS))
  chk (.clk, .rst, .supply_rail_low_in, .manual_reset_n_in, .watchdog_kick_in,
  .watchdog_kick_float_in, .power_fail_sense_in, .reset_n_out, .reset_out,
  .watchdog_timeout_n_out, .power_fail_warn_n_out);
